// ==== dv/pldh_checker.sv ====
// Port-level concurrent checks for the lock-detect and holdover controller
`timescale 1ns/10ps
`default_nettype none
module pldh_checker (
  // Clock, enable and reset
  input wire logic clk_sys,
  input wire logic clk_en,
  input wire logic srst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Loop side
  input wire logic pd_strobe,
  input wire logic ref_valid,
  input wire logic [pldh_pkg::DAC_W-1:0] loop_tune,
  input wire logic lock_detect_flag,
  input wire logic holdover_active,
  input wire logic [pldh_pkg::DAC_W-1:0] tune_value
);
  // ---------------------------------------------------------------------------
  // Checks, frozen while the enable is low
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst || !clk_en);
  // A fresh request waiting for its answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  chk_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("bus request not answered");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
  chk_flag_rise: assert property ($rose(lock_detect_flag) |->
    $past(pd_strobe) && !holdover_active) else $error("flag rose without comparison");
  chk_flag_fall: assert property ($fell(lock_detect_flag) |-> $past(pd_strobe))
    else $error("flag fell without comparison");
  chk_hold_entry: assert property ($rose(holdover_active) |-> $fell(lock_detect_flag))
    else $error("holdover entered without lock loss");
  chk_hold_exit: assert property (holdover_active && ref_valid |=> !holdover_active)
    else $error("holdover kept with valid reference");
  chk_relock_fresh: assert property ($fell(holdover_active) |-> !lock_detect_flag)
    else $error("flag high at holdover exit");
  chk_tune_normal: assert property (!holdover_active && $past(clk_en && !srst) |->
    tune_value == $past(loop_tune)) else $error("tune value not loop value");
endmodule : pldh_checker
bind pldh_ctrl pldh_checker u_pldh_checker (.clk_sys, .clk_en, .srst, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .pd_strobe, .ref_valid, .loop_tune,
  .lock_detect_flag, .holdover_active, .tune_value);
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the lock-detect and holdover controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic clk_en = 1'b1;
  logic srst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, rd;
  logic wb_ack_o, pd_strobe = 1'b0, ref_valid = 1'b0;
  logic lock_detect_flag, holdover_active, irq;
  logic [pldh_pkg::WND_W-1:0] pd_phase_err = 8'h00;
  logic [pldh_pkg::DAC_W-1:0] loop_tune = 10'h123, tune_value;
  int fail_count = 0, n_compared = 0, cycles = 0;
  // Clock
  always #25 clk_sys = ~clk_sys;
  pldh_ctrl u_pldh_ctrl (.clk_sys, .clk_en, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pd_strobe, .pd_phase_err,
    .ref_valid, .loop_tune, .lock_detect_flag, .holdover_active, .tune_value, .irq);
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // One classic cycle, held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1) @(posedge clk_sys);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_xfer
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    wb_xfer(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask : rchk
  // One comparison, then wait for the flag edge
  task automatic strobe(input logic [7:0] e);
    @(posedge clk_sys);
    pd_strobe <= 1'b1;
    pd_phase_err <= e;
    @(posedge clk_sys);
    pd_strobe <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : strobe
  task automatic lock3;
    for (int i = 0; i < 3; i++) strobe(8'h05);
  endtask : lock3
  // Valid reference for two edges, then holdover must be over
  task automatic exit_ho;
    @(posedge clk_sys);
    ref_valid <= 1'b1;
    repeat (2) @(posedge clk_sys);
    ref_valid <= 1'b0;
    #1;
    chk(holdover_active, 32'h0);
    chk(tune_value, 32'h00000123);
  endtask : exit_ho
  // Hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    rchk(pldh_pkg::ADR_CTRL, 32'h0000000A);
    rchk(pldh_pkg::ADR_LOCK_CNT, 32'h00002710);
    rchk(pldh_pkg::ADR_DAC, 32'h00000200);
    rchk(pldh_pkg::ADR_WINDOW, 32'h00000010);
    rchk(8'h20, 32'h00000000);
    wb_xfer(1'b1, pldh_pkg::ADR_LOCK_CNT, 32'h00000003);
    wb_xfer(1'b1, pldh_pkg::ADR_DAC, 32'h00000155);
    wb_xfer(1'b1, pldh_pkg::ADR_IRQ_MASK, 32'h0000000F);
    // Window edge counts, one past it restarts the count
    strobe(8'h10);
    strobe(8'h10);
    strobe(8'h11);
    strobe(8'h01);
    strobe(8'h02);
    chk(lock_detect_flag, 32'h0);
    strobe(8'h03);
    chk(lock_detect_flag, 32'h1);
    chk(irq, 32'h1);
    rchk(pldh_pkg::ADR_IRQ_STAT, 32'h00000001);
    wb_xfer(1'b1, pldh_pkg::ADR_IRQ_STAT, 32'h00000001);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(irq, 32'h0);
    // Lock loss enters holdover on the manual voltage
    strobe(8'h11);
    chk(lock_detect_flag, 32'h0);
    chk(holdover_active, 32'h1);
    chk(tune_value, 32'h00000155);
    rchk(pldh_pkg::ADR_STATUS, 32'h00000002);
    rchk(pldh_pkg::ADR_IRQ_STAT, 32'h00000006);
    exit_ho();
    // Fixed mid-scale voltage with tracking and manual value off
    wb_xfer(1'b1, pldh_pkg::ADR_CTRL, 32'h00000002);
    lock3();
    strobe(8'h20);
    chk(holdover_active, 32'h1);
    chk(tune_value, 32'h00000200);
    exit_ho();
    // Tracking holds the last loop value seen before entry
    wb_xfer(1'b1, pldh_pkg::ADR_CTRL, 32'h00000006);
    loop_tune <= 10'h0AB;
    lock3();
    strobe(8'h20);
    loop_tune <= 10'h123;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(holdover_active, 32'h1);
    chk(tune_value, 32'h000000AB);
    exit_ho();
    // Lock loss with holdover entry disabled, first while frozen
    wb_xfer(1'b1, pldh_pkg::ADR_CTRL, 32'h00000012);
    lock3();
    chk(lock_detect_flag, 32'h1);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    strobe(8'h20);
    chk(lock_detect_flag, 32'h1);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    strobe(8'h20);
    chk(lock_detect_flag, 32'h0);
    chk(holdover_active, 32'h0);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire

// ==== logic/pldh_ctrl.sv ====
// Lock-detect qualification and holdover control with a Wishbone slave
// Operation
// RULE1 - Lock time set by count and detector rate
// RULE2 - Flag rises after count in-window comparisons
// RULE3 - Flag drops when phase error leaves window
// RULE4 - Lock loss enters holdover unless disabled
// RULE5 - Valid reference exits holdover, relock begins
// RULE6 - Select two enables holdover; track off fixes
// RULE7 - Manual DAC value drives holdover tuning
// RULE8 - Software sets lock count large enough
// RULE9 - Out-of-window comparison restarts count at zero
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module pldh_ctrl (
  // Clock, enable and reset
  input wire logic clk_sys,
  input wire logic clk_en,
  input wire logic srst,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Phase detector side
  input wire logic pd_strobe,
  input wire logic [pldh_pkg::WND_W-1:0] pd_phase_err,
  input wire logic ref_valid,
  input wire logic [pldh_pkg::DAC_W-1:0] loop_tune,
  // Control outputs
  output logic lock_detect_flag,
  output logic holdover_active,
  output logic [pldh_pkg::DAC_W-1:0] tune_value,
  output logic irq
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] pldh_wmask(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : pldh_wmask

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [pldh_pkg::CTRL_W-1:0] ctrl_q;
  logic [pldh_pkg::CTRL_W-1:0] ctrl_d;
  logic [pldh_pkg::CNT_W-1:0] lock_cnt_q;
  logic [pldh_pkg::CNT_W-1:0] lock_cnt_d;
  logic [pldh_pkg::WND_W-1:0] window_q;
  logic [pldh_pkg::WND_W-1:0] window_d;
  logic [pldh_pkg::DAC_W-1:0] dac_q;
  logic [pldh_pkg::DAC_W-1:0] dac_d;
  logic [pldh_pkg::IRQ_W-1:0] istat_q;
  logic [pldh_pkg::IRQ_W-1:0] istat_d;
  logic [pldh_pkg::IRQ_W-1:0] imask_q;
  logic [pldh_pkg::IRQ_W-1:0] imask_d;
  logic [pldh_pkg::CNT_W-1:0] qual_q;
  logic [pldh_pkg::CNT_W-1:0] qual_d;
  logic [pldh_pkg::DAC_W-1:0] held_q;
  logic [pldh_pkg::DAC_W-1:0] held_d;
  logic [pldh_pkg::DAC_W-1:0] tune_d;
  logic lock_q;
  logic lock_d;
  logic ack_q;
  logic irq_d;
  logic [31:0] rdat_d;
  pldh_pkg::pldh_state_t state_q;
  pldh_pkg::pldh_state_t state_d;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  wire logic bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic bus_wr = bus_req && wb_we_i;
  wire logic hit_ctrl = (wb_adr_i == pldh_pkg::ADR_CTRL);
  wire logic hit_cnt = (wb_adr_i == pldh_pkg::ADR_LOCK_CNT);
  wire logic hit_wnd = (wb_adr_i == pldh_pkg::ADR_WINDOW);
  wire logic hit_dac = (wb_adr_i == pldh_pkg::ADR_DAC);
  wire logic hit_st = (wb_adr_i == pldh_pkg::ADR_STATUS);
  wire logic hit_is = (wb_adr_i == pldh_pkg::ADR_IRQ_STAT);
  wire logic hit_im = (wb_adr_i == pldh_pkg::ADR_IRQ_MASK);
  wire logic hit_tn = (wb_adr_i == pldh_pkg::ADR_TUNE);
  wire logic [31:0] wr_ctrl = pldh_wmask(32'({ctrl_q}), wb_dat_i, wb_sel_i);
  wire logic [31:0] wr_cnt = pldh_wmask(32'({lock_cnt_q}), wb_dat_i, wb_sel_i);
  wire logic [31:0] wr_wnd = pldh_wmask(32'({window_q}), wb_dat_i, wb_sel_i);
  wire logic [31:0] wr_dac = pldh_wmask(32'({dac_q}), wb_dat_i, wb_sel_i);
  wire logic [31:0] wr_im = pldh_wmask(32'({imask_q}), wb_dat_i, wb_sel_i);
  wire logic [31:0] wr_w1c = pldh_wmask(32'h0000_0000, wb_dat_i, wb_sel_i);

  // Register write next values
  assign ctrl_d = (bus_wr && hit_ctrl) ? wr_ctrl[pldh_pkg::CTRL_W-1:0] : ctrl_q;
  assign lock_cnt_d = (bus_wr && hit_cnt) ? wr_cnt[pldh_pkg::CNT_W-1:0] : lock_cnt_q;
  assign window_d = (bus_wr && hit_wnd) ? wr_wnd[pldh_pkg::WND_W-1:0] : window_q;
  assign dac_d = (bus_wr && hit_dac) ? wr_dac[pldh_pkg::DAC_W-1:0] : dac_q;
  assign imask_d = (bus_wr && hit_im) ? wr_im[pldh_pkg::IRQ_W-1:0] : imask_q;

  // ---------------------------------------------------------------------------
  // Lock qualification
  // ---------------------------------------------------------------------------
  wire logic [1:0] ho_sel = ctrl_q[pldh_pkg::CTRL_HO_SEL_HI:pldh_pkg::CTRL_HO_SEL_LO];
  wire logic ho_enabled = (ho_sel == pldh_pkg::HO_SEL_ENABLED); // RULE6
  wire logic track_en = ctrl_q[pldh_pkg::CTRL_TRACK];
  wire logic manual_dac_value_en = ctrl_q[pldh_pkg::CTRL_MANUAL_DAC_VALUE];
  wire logic ll_disable = ctrl_q[pldh_pkg::CTRL_LL_DIS];
  wire logic in_window = (pd_phase_err <= window_q);
  wire logic in_hold = (state_q == pldh_pkg::PLDH_HOLDOVER);
  // Count reaches target in this comparison; count of zero behaves as one
  wire logic qual_hit = (qual_q + pldh_pkg::CNT_ONE >= lock_cnt_q);
  wire logic [pldh_pkg::CNT_W-1:0] qual_inc = (qual_q == lock_cnt_q) ? qual_q
                                              : qual_q + pldh_pkg::CNT_ONE;

  // Lock time is lock_cnt_q strobes, one per phase detector cycle
  assign qual_d = in_hold ? '0 // RULE1
                : !pd_strobe ? qual_q
                : !in_window ? '0 // RULE9
                : qual_inc;
  assign lock_d = in_hold ? 1'b0
                : !pd_strobe ? lock_q
                : !in_window ? 1'b0 // RULE3
                : (qual_hit ? 1'b1 : lock_q); // RULE2

  wire logic lock_rise = lock_d && !lock_q;
  wire logic lock_fall = !lock_d && lock_q && !in_hold;

  // ---------------------------------------------------------------------------
  // Holdover state machine
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      pldh_pkg::PLDH_ACQUIRE: begin
        if (lock_rise) begin
          state_d = pldh_pkg::PLDH_LOCKED;
        end
      end
      pldh_pkg::PLDH_LOCKED: begin
        if (lock_fall && ho_enabled && !ll_disable) begin
          state_d = pldh_pkg::PLDH_HOLDOVER; // RULE4
        end else if (lock_fall) begin
          state_d = pldh_pkg::PLDH_ACQUIRE;
        end
      end
      pldh_pkg::PLDH_HOLDOVER: begin
        if (ref_valid || !ho_enabled) begin
          state_d = pldh_pkg::PLDH_ACQUIRE; // RULE5
        end
      end
      default: begin
        state_d = pldh_pkg::PLDH_ACQUIRE;
      end
    endcase
  end

  wire logic ho_enter = (state_d == pldh_pkg::PLDH_HOLDOVER) && !in_hold;
  wire logic ho_exit = in_hold && (state_d != pldh_pkg::PLDH_HOLDOVER);

  // Last loop voltage seen outside holdover, used when tracking
  assign held_d = in_hold ? held_q : loop_tune;

  // Holdover voltage: manual DAC, tracked value, or fixed midpoint
  wire logic [pldh_pkg::DAC_W-1:0] ho_volt = manual_dac_value_en ? dac_q // RULE7
                                           : track_en ? held_q
                                           : pldh_pkg::DAC_RST; // RULE6
  assign tune_d = (state_d == pldh_pkg::PLDH_HOLDOVER) ? ho_volt : loop_tune;

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------
  wire logic [pldh_pkg::IRQ_W-1:0] ev = {ho_exit, ho_enter, lock_fall, lock_rise};
  wire logic [pldh_pkg::IRQ_W-1:0] clr = (bus_wr && hit_is) ? wr_w1c[pldh_pkg::IRQ_W-1:0] : '0;
  // New events win over a same-cycle clear
  assign istat_d = (istat_q & ~clr) | ev;
  assign irq_d = |(istat_d & imask_d);

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  wire logic [2:0] status_v = {ref_valid, in_hold, lock_q};
  always_comb begin
    if (hit_ctrl) begin
      rdat_d = 32'({ctrl_q});
    end else if (hit_cnt) begin
      rdat_d = 32'({lock_cnt_q});
    end else if (hit_wnd) begin
      rdat_d = 32'({window_q});
    end else if (hit_dac) begin
      rdat_d = 32'({dac_q});
    end else if (hit_st) begin
      rdat_d = 32'({status_v});
    end else if (hit_is) begin
      rdat_d = 32'({istat_q});
    end else if (hit_im) begin
      rdat_d = 32'({imask_q});
    end else if (hit_tn) begin
      rdat_d = 32'({tune_value});
    end else begin
      rdat_d = 32'h0000_0000; // Unmapped reads zero, writes dropped
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_q <= pldh_pkg::CTRL_RST;
      lock_cnt_q <= pldh_pkg::LOCK_CNT_RST; // RULE8
      window_q <= pldh_pkg::WINDOW_RST;
      dac_q <= pldh_pkg::DAC_RST;
      imask_q <= '0;
    end else if (clk_en) begin
      ctrl_q <= ctrl_d;
      lock_cnt_q <= lock_cnt_d;
      window_q <= window_d;
      dac_q <= dac_d;
      imask_q <= imask_d;
    end
  end

  // Bus answer, one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_q <= 1'b0;
      wb_dat_o <= '0;
    end else if (clk_en) begin
      ack_q <= bus_req;
      wb_dat_o <= bus_req ? rdat_d : '0;
    end
  end
  assign wb_ack_o = ack_q;

  // Lock and holdover state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= pldh_pkg::PLDH_ACQUIRE;
      qual_q <= '0;
      lock_q <= 1'b0;
      held_q <= pldh_pkg::DAC_RST;
      istat_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      qual_q <= qual_d;
      lock_q <= lock_d;
      held_q <= held_d;
      istat_q <= istat_d;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lock_detect_flag <= 1'b0;
      holdover_active <= 1'b0;
      tune_value <= pldh_pkg::DAC_RST;
      irq <= 1'b0;
    end else if (clk_en) begin
      lock_detect_flag <= lock_d;
      holdover_active <= (state_d == pldh_pkg::PLDH_HOLDOVER);
      tune_value <= tune_d;
      irq <= irq_d;
    end
  end

endmodule : pldh_ctrl
`default_nettype wire

// ==== logic/pldh_pkg.sv ====
// Package of constants and types for the lock-detect and holdover controller
package pldh_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_LOCK_CNT = 8'h04;
  localparam logic [7:0] ADR_WINDOW = 8'h08;
  localparam logic [7:0] ADR_DAC = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADR_TUNE = 8'h1C;

  // ---------------------------------------------------------------------------
  // Field widths and positions
  // ---------------------------------------------------------------------------
  localparam int CNT_W = 14;
  localparam int WND_W = 8;
  localparam int DAC_W = 10;
  localparam int CTRL_W = 5;
  localparam int IRQ_W = 4;
  localparam int CTRL_HO_SEL_LO = 0;
  localparam int CTRL_HO_SEL_HI = 1;
  localparam int CTRL_TRACK = 2;
  localparam int CTRL_MANUAL_DAC_VALUE = 3;
  localparam int CTRL_LL_DIS = 4;
  localparam int ST_LOCK = 0;
  localparam int ST_HOLD = 1;
  localparam int ST_REF = 2;
  localparam int IRQ_LOCK_SET = 0;
  localparam int IRQ_LOCK_LOST = 1;
  localparam int IRQ_HO_ENTER = 2;
  localparam int IRQ_HO_EXIT = 3;

  // ---------------------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------------------
  localparam logic [1:0] HO_SEL_ENABLED = 2'h2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h0A;
  localparam logic [CNT_W-1:0] LOCK_CNT_RST = 14'h2710;
  localparam logic [WND_W-1:0] WINDOW_RST = 8'h10;
  localparam logic [DAC_W-1:0] DAC_RST = 10'h200;
  localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;

  typedef enum logic [1:0] {
    PLDH_ACQUIRE,
    PLDH_LOCKED,
    PLDH_HOLDOVER
  } pldh_state_t;

endpackage : pldh_pkg
